// ### hw/ccm_edge.sv
`timescale 1ns/1ps
module ccm_edge (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // Control
    input  wire logic       clear_in,
    input  wire logic [1:0] sel_in,
    // Pin level and event
    input  wire logic       level_in,
    output logic            event_out
);
    ccm_pkg::ccm_edge_state_t r;
    ccm_pkg::ccm_edge_state_t next_r;
    logic rise;
    logic fall;

    always_comb begin
        rise = level_in & ~r.prev;
        fall = ~level_in & r.prev;
        next_r = r;
        next_r.prev = level_in;
        event_out = 1'b0;
        if (clear_in) begin
            next_r.cnt = '0;
        end else begin
            case (sel_in)
                ccm_pkg::CCM_SEL_FALL: event_out = fall;
                ccm_pkg::CCM_SEL_RISE: event_out = rise;
                ccm_pkg::CCM_SEL_DIV4: begin
                    event_out = rise && (r.cnt[1:0] == ccm_pkg::CCM_DIV4_LAST);
                end
                default: begin
                    event_out = rise && (r.cnt == ccm_pkg::CCM_DIV16_LAST);
                end
            endcase
            // The count runs on in every capture mode, so a switch between
            // prescale settings keeps it.
            if (rise) begin
                next_r.cnt = r.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    a_presc_cleared: assert property (
        @(posedge clk_in) disable iff (rst_in)
        clear_in |=> r.cnt == '0) else $error("prescaler not cleared");
    a_div16_event: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (!clear_in && sel_in == ccm_pkg::CCM_SEL_DIV16 && rise)
        |-> event_out == (r.cnt == 4'hF)) else $error("bad 16th edge");
    a_count_kept: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (!clear_in && !rise) |=> $stable(r.cnt))
        else $error("prescaler moved without edge");
endmodule

// ### hw/ccm_pkg.sv
package ccm_pkg;

    // Register addresses on the byte-wide register port.
    localparam logic [7:0] CCM_ADDR_DATA = 8'h07;
    localparam logic [7:0] CCM_ADDR_FLAG = 8'h0C;
    localparam logic [7:0] CCM_ADDR_LOW  = 8'h15;
    localparam logic [7:0] CCM_ADDR_HIGH = 8'h16;
    localparam logic [7:0] CCM_ADDR_CTRL = 8'h17;
    localparam logic [7:0] CCM_ADDR_DIR  = 8'h87;
    localparam logic [7:0] CCM_ADDR_IEN  = 8'h8C;

    // Bit positions of the single-bit fields, and the control field width.
    localparam int CCM_PIN_BIT  = 2;
    localparam int CCM_FLAG_BIT = 2;
    localparam int CCM_CTRL_W   = 6;

    // Values after reset.
    localparam logic [5:0] CCM_CTRL_RESET = 6'h00;
    localparam logic       CCM_DIR_RESET  = 1'b1;

    // Mode select field codes and mode groups.
    localparam logic [3:0] CCM_MODE_OFF  = 4'h0;
    localparam logic [3:0] CCM_MODE_SET  = 4'h8;
    localparam logic [3:0] CCM_MODE_CLR  = 4'h9;
    localparam logic [3:0] CCM_MODE_SWI  = 4'hA;
    localparam logic [3:0] CCM_MODE_SPEC = 4'hB;
    localparam logic [1:0] CCM_GRP_CAP   = 2'h1;
    localparam logic [1:0] CCM_GRP_CMP   = 2'h2;
    localparam logic [1:0] CCM_GRP_PWM   = 2'h3;

    // Capture event selection, low two bits of a capture mode.
    localparam logic [1:0] CCM_SEL_FALL  = 2'h0;
    localparam logic [1:0] CCM_SEL_RISE  = 2'h1;
    localparam logic [1:0] CCM_SEL_DIV4  = 2'h2;
    localparam logic [1:0] CCM_SEL_DIV16 = 2'h3;

    // Edge prescaler counter.
    localparam int         CCM_PRESC_W   = 4;
    localparam logic [1:0] CCM_DIV4_LAST = 2'h3;
    localparam logic [3:0] CCM_DIV16_LAST = 4'hF;

    typedef struct packed {
        logic       sync0;
        logic       sync1;
        logic [5:0] ctrl;
        logic [7:0] val_lo;
        logic [7:0] val_hi;
        logic       dir;
        logic       data_latch;
        logic       flag;
        logic       irq_en;
        logic       cmp_latch;
        logic       match_prev;
        logic [7:0] rdata;
    } ccm_top_state_t;

    typedef struct packed {
        logic                   prev;
        logic [CCM_PRESC_W-1:0] cnt;
    } ccm_edge_state_t;

    typedef struct packed {
        logic [1:0] frac;
        logic       level;
    } ccm_pwm_state_t;

    localparam ccm_top_state_t CCM_TOP_RESET =
        '{dir: CCM_DIR_RESET, ctrl: CCM_CTRL_RESET, default: '0};

endpackage

// ### hw/ccm_pwm.sv
`timescale 1ns/1ps
module ccm_pwm (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // Enable and duty values
    input  wire logic       enable_in,
    input  wire logic [9:0] duty_new_in,
    input  wire logic [7:0] duty_hi_in,
    // Period timer
    input  wire logic       reload_in,
    input  wire logic [7:0] count_in,
    input  wire logic [1:0] phase_in,
    // Outputs
    output logic            load_out,
    output logic            level_out
);
    ccm_pkg::ccm_pwm_state_t r;
    ccm_pkg::ccm_pwm_state_t next_r;
    logic hit;

    always_comb begin
        next_r = r;
        load_out = enable_in & reload_in;
        hit = ({duty_hi_in, r.frac} == {count_in, phase_in});
        if (!enable_in) begin
            next_r = '0;
        end else if (reload_in) begin
            // A zero duty never raises the output.
            next_r.level = (duty_new_in != 10'h000);
            next_r.frac = duty_new_in[1:0];
        end else if (hit) begin
            next_r.level = 1'b0;
        end
        level_out = r.level;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    a_pwm_reload: assert property (
        @(posedge clk_in) disable iff (rst_in)
        load_out |=> level_out == ($past(duty_new_in) != 10'h000))
        else $error("pwm start level wrong");
    a_pwm_clear: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (enable_in && !reload_in && hit) |=> !level_out)
        else $error("pwm not cleared on duty match");
endmodule

// ### hw/ccm_top.sv
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module ccm_top (
    // Clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        RST_IN,
    // Register port
    input  wire logic [7:0]  ADDR_IN,
    input  wire logic [7:0]  WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic      [7:0]  RDATA_OUT,
    // Capture/compare pin
    input  wire logic        CC_PIN_IN,
    output logic             CC_PIN_OUT,
    output logic             CC_PIN_OE_OUT,
    // Sixteen-bit timer
    input  wire logic [15:0] TIMER_COUNT_IN,
    output logic             TIMER_RESET_OUT,
    // Eight-bit period timer
    input  wire logic [7:0]  PERIOD_COUNT_IN,
    input  wire logic [1:0]  PERIOD_PHASE_IN,
    input  wire logic        PERIOD_RELOAD_IN,
    // Converter
    input  wire logic        ADC_ENABLE_IN,
    output logic             ADC_START_OUT,
    // Interrupt
    output logic             IRQ_OUT
);
    ccm_pkg::ccm_top_state_t r;
    ccm_pkg::ccm_top_state_t next_r;

    logic [3:0]  mode;
    logic        is_cap;
    logic        is_cmp;
    logic        is_pwm;
    logic        pin_drive;
    logic        pin_level;
    logic        cmp_eq;
    logic        cmp_hit;
    logic        special;
    logic        cap_evt;
    logic        pwm_load;
    logic        pwm_level;
    logic        wr_low;
    logic        wr_high;
    logic        wr_flag;
    logic [7:0]  rd_val;
    logic [15:0] value;

    // Mode decode.
    always_comb begin
        mode = r.ctrl[3:0];
        is_cap = (mode[3:2] == ccm_pkg::CCM_GRP_CAP);
        is_cmp = (mode[3:2] == ccm_pkg::CCM_GRP_CMP);
        is_pwm = (mode[3:2] == ccm_pkg::CCM_GRP_PWM);
        value = {r.val_hi, r.val_lo};
    end

    // Prescaler is held clear outside capture modes.
    ccm_edge u_edge (
        .clk_in    (CLK_IN),
        .rst_in    (RST_IN),
        .clear_in  (~is_cap),
        .sel_in    (mode[1:0]),
        .level_in  (pin_level),
        .event_out (cap_evt)
    );

    ccm_pwm u_pwm (
        .clk_in      (CLK_IN),
        .rst_in      (RST_IN),
        .enable_in   (is_pwm),
        .duty_new_in ({r.val_lo, r.ctrl[5:4]}),
        .duty_hi_in  (r.val_hi),
        .reload_in   (PERIOD_RELOAD_IN),
        .count_in    (PERIOD_COUNT_IN),
        .phase_in    (PERIOD_PHASE_IN),
        .load_out    (pwm_load),
        .level_out   (pwm_level)
    );

    // Pin, compare and strobe logic.
    always_comb begin
        pin_drive = ~r.dir;
        if (is_pwm) begin
            CC_PIN_OUT = pwm_level;
        end else if (is_cmp) begin
            CC_PIN_OUT = r.cmp_latch;
        end else begin
            CC_PIN_OUT = r.data_latch;
        end
        CC_PIN_OE_OUT = pin_drive;
        // A driven pin is seen at its own output value, so a write to the
        // data latch bit can make a capture edge.
        pin_level = pin_drive ? CC_PIN_OUT : r.sync1;
        cmp_eq = (TIMER_COUNT_IN == value);
        // One hit per match, even if the timer dwells on the value.
        cmp_hit = is_cmp & cmp_eq & ~r.match_prev;
        special = cmp_hit & (mode == ccm_pkg::CCM_MODE_SPEC);
        TIMER_RESET_OUT = special;
        ADC_START_OUT = special & ADC_ENABLE_IN;
        IRQ_OUT = r.flag & r.irq_en;
        RDATA_OUT = r.rdata;
    end

    // Register write decode.
    always_comb begin
        wr_low = WR_IN && (ADDR_IN == ccm_pkg::CCM_ADDR_LOW);
        wr_high = WR_IN && (ADDR_IN == ccm_pkg::CCM_ADDR_HIGH);
        wr_flag = WR_IN && (ADDR_IN == ccm_pkg::CCM_ADDR_FLAG);
    end

    // Read mux; unmapped addresses and unused bits read zero.
    always_comb begin
        rd_val = 8'h00;
        case (ADDR_IN)
            ccm_pkg::CCM_ADDR_DATA: begin
                rd_val[ccm_pkg::CCM_PIN_BIT] = r.data_latch;
            end
            ccm_pkg::CCM_ADDR_FLAG: begin
                rd_val[ccm_pkg::CCM_FLAG_BIT] = r.flag;
            end
            ccm_pkg::CCM_ADDR_LOW: begin
                rd_val = r.val_lo;
            end
            ccm_pkg::CCM_ADDR_HIGH: begin
                rd_val = r.val_hi;
            end
            ccm_pkg::CCM_ADDR_CTRL: begin
                rd_val = {2'h0, r.ctrl};
            end
            ccm_pkg::CCM_ADDR_DIR: begin
                rd_val[ccm_pkg::CCM_PIN_BIT] = r.dir;
            end
            ccm_pkg::CCM_ADDR_IEN: begin
                rd_val[ccm_pkg::CCM_FLAG_BIT] = r.irq_en;
            end
            default: begin
                rd_val = 8'h00;
            end
        endcase
    end

    // Next state.
    always_comb begin
        next_r = r;
        next_r.sync0 = CC_PIN_IN;
        next_r.sync1 = r.sync0;
        next_r.match_prev = is_cmp & cmp_eq;
        next_r.rdata = RD_IN ? rd_val : 8'h00;

        if (WR_IN) begin
            case (ADDR_IN)
                ccm_pkg::CCM_ADDR_CTRL: begin
                    next_r.ctrl = WDATA_IN[ccm_pkg::CCM_CTRL_W-1:0];
                end
                ccm_pkg::CCM_ADDR_DATA: begin
                    next_r.data_latch = WDATA_IN[ccm_pkg::CCM_PIN_BIT];
                end
                ccm_pkg::CCM_ADDR_DIR: begin
                    next_r.dir = WDATA_IN[ccm_pkg::CCM_PIN_BIT];
                end
                ccm_pkg::CCM_ADDR_IEN: begin
                    next_r.irq_en = WDATA_IN[ccm_pkg::CCM_FLAG_BIT];
                end
                default: begin
                    next_r.ctrl = r.ctrl;
                end
            endcase
        end

        // Value bytes: software writes, then capture and PWM reload win.
        if (wr_low) begin
            next_r.val_lo = WDATA_IN;
        end
        // The high byte is read-only while PWM owns it.
        if (wr_high && !is_pwm) begin
            next_r.val_hi = WDATA_IN;
        end
        if (cap_evt) begin
            next_r.val_lo = TIMER_COUNT_IN[7:0];
            next_r.val_hi = TIMER_COUNT_IN[15:8];
        end
        if (pwm_load) begin
            next_r.val_hi = r.val_lo;
        end

        // Compare output latch.
        if (mode == ccm_pkg::CCM_MODE_OFF) begin
            next_r.cmp_latch = 1'b0;
        end else if (cmp_hit && mode == ccm_pkg::CCM_MODE_SET) begin
            next_r.cmp_latch = 1'b1;
        end else if (cmp_hit && mode == ccm_pkg::CCM_MODE_CLR) begin
            next_r.cmp_latch = 1'b0;
        end

        // Sticky flag, cleared by writing one; a same-cycle event wins.
        if (wr_flag && WDATA_IN[ccm_pkg::CCM_FLAG_BIT]) begin
            next_r.flag = 1'b0;
        end
        if (cap_evt || cmp_hit) begin
            next_r.flag = 1'b1;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            r <= ccm_pkg::CCM_TOP_RESET;
        end else begin
            r <= next_r;
        end
    end

    a_capture_copy: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        cap_evt |=> value == $past(TIMER_COUNT_IN))
        else $error("capture did not copy timer");
    a_capture_flag: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        cap_evt |=> r.flag && IRQ_OUT == r.irq_en)
        else $error("capture did not set flag");
    // A pending flag means the previous value may be unread.
    a_capture_overwrite: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (cap_evt && r.flag) |=> value == $past(TIMER_COUNT_IN))
        else $error("second capture lost");
    a_flag_held: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (r.flag && !wr_flag) |=> r.flag)
        else $error("flag dropped by hardware");
    a_set_on_match: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (cmp_hit && mode == ccm_pkg::CCM_MODE_SET) |=> r.cmp_latch)
        else $error("set on match failed");
    a_swint_pin: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (cmp_hit && mode == ccm_pkg::CCM_MODE_SWI)
        |=> $stable(r.cmp_latch) && r.flag)
        else $error("software interrupt mode wrong");
    a_special_event: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (cmp_hit && mode == ccm_pkg::CCM_MODE_SPEC)
        |-> TIMER_RESET_OUT && ADC_START_OUT == ADC_ENABLE_IN)
        else $error("special event strobes wrong");
    a_off_resets: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (mode == ccm_pkg::CCM_MODE_OFF) |=> !r.cmp_latch)
        else $error("off did not reset latch");
    a_driven_level: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (!r.dir && !is_cmp && !is_pwm) |-> pin_level == r.data_latch)
        else $error("driven pin not seen by capture");
    a_low_write: assert property (
        @(posedge CLK_IN) disable iff (RST_IN)
        (wr_low && !cap_evt) |=> r.val_lo == $past(WDATA_IN))
        else $error("low byte write lost");
endmodule

// ### tb/ccm_far_side.sv
`timescale 1ns/1ps
module ccm_far_side (
    // Clock
    input  wire logic        clk_in,
    // Capture/compare pin
    input  wire logic        ext_level_in,
    input  wire logic        pin_out_in,
    input  wire logic        pin_oe_in,
    output logic             pin_level_out,
    // Sixteen-bit timer
    input  wire logic        load_in,
    input  wire logic [15:0] value_in,
    input  wire logic        run_in,
    input  wire logic        reset_in,
    output logic      [15:0] count_out
);
    // A driven pin shows the unit's own output, so it can capture itself.
    assign pin_level_out = pin_oe_in ? pin_out_in : ext_level_in;

    // The timer counts on the unit's own clock, as capture needs.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            count_out <= 16'h0000;
        end else if (load_in) begin
            count_out <= value_in;
        end else if (run_in) begin
            count_out <= count_out + 16'h0001;
        end
    end
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        clk;
    logic        rst;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        pin_in;
    logic        pin_out;
    logic        pin_oe;
    logic [15:0] tmr;
    logic        tmr_rst;
    logic [7:0]  per_cnt;
    logic [1:0]  per_ph;
    logic        per_rl;
    logic        adc_en;
    logic        adc_go;
    logic        irq;
    logic        ext;
    logic        tld;
    logic [15:0] tval;
    logic        trun;
    logic [7:0]  got;
    int          miscompares;
    int          checks;
    int          cycles;
    int          seed;
    int          mode;
    int          cnt;
    int          en;
    int          flag;
    int          val;
    int          i;
    int          k;
    logic [7:0]  rst_adr[6] = '{8'h17, 8'h87, 8'h15, 8'h16, 8'h0C, 8'h33};
    logic [7:0]  rst_val[6] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
    int          cmp_mode[5] = '{10, 8, 10, 9, 8};
    logic        cmp_pin[5]  = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};

    ccm_top dut (
        .CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .CC_PIN_IN(pin_in), .CC_PIN_OUT(pin_out), .CC_PIN_OE_OUT(pin_oe),
        .TIMER_COUNT_IN(tmr), .TIMER_RESET_OUT(tmr_rst),
        .PERIOD_COUNT_IN(per_cnt), .PERIOD_PHASE_IN(per_ph),
        .PERIOD_RELOAD_IN(per_rl), .ADC_ENABLE_IN(adc_en),
        .ADC_START_OUT(adc_go), .IRQ_OUT(irq)
    );

    ccm_far_side far (
        .clk_in(clk), .ext_level_in(ext), .pin_out_in(pin_out),
        .pin_oe_in(pin_oe), .pin_level_out(pin_in), .load_in(tld),
        .value_in(tval), .run_in(trun), .reset_in(tmr_rst),
        .count_out(tmr)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic complete_run();
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            miscompares = miscompares + 1;
            complete_run();
        end
    end

    task automatic chk8(input string n, input logic [7:0] e,
                        input logic [7:0] g);
        checks = checks + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk1(input string n, input logic e, input logic g);
        checks = checks + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_reg(input logic [7:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        got = rdata;
    endtask

    // Leaving capture clears the model's prescaler, as the unit must.
    task automatic set_mode(input int m);
        wr_reg(ccm_pkg::CCM_ADDR_CTRL, 8'(m));
        mode = m & 15;
        if (mode < 4 || mode > 7) begin
            cnt = 0;
        end
    endtask

    task automatic chk_state();
        rd_reg(ccm_pkg::CCM_ADDR_LOW);
        chk8("low", val[7:0], got);
        rd_reg(ccm_pkg::CCM_ADDR_HIGH);
        chk8("high", val[15:8], got);
        chk1("irq", 1'(flag & en), irq);
        rd_reg(ccm_pkg::CCM_ADDR_FLAG);
        chk8("flag", 8'(flag * 4), got);
        if (flag != 0 && en != 0) begin
            wr_reg(ccm_pkg::CCM_ADDR_FLAG, 8'h04);
            flag = 0;
        end
    endtask

    // One pin change, external or from the data latch, then a compare.
    task automatic pin_step(input logic lvl, input logic drive);
        int cap;
        tval <= 16'($random(seed));
        @(posedge clk);
        if (drive) begin
            wr_reg(ccm_pkg::CCM_ADDR_DATA, {5'h00, lvl, 2'h0});
        end else begin
            ext <= lvl;
        end
        repeat (6) @(posedge clk);
        if (lvl) begin
            cap = (mode == 5) || (mode == 6 && cnt % 4 == 3)
                || (mode == 7 && cnt % 16 == 15);
            cnt = (cnt + 1) % 16;
        end else begin
            cap = (mode == 4);
        end
        if (cap != 0) begin
            val = tval;
            flag = 1;
        end
        chk_state();
    endtask

    initial begin
        seed = 55;
        rst = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        ext = 1'b0;
        tld = 1'b1;
        tval = 16'h0000;
        trun = 1'b0;
        per_cnt = 8'h00;
        per_ph = 2'h0;
        per_rl = 1'b0;
        adc_en = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 6; i++) begin
            rd_reg(rst_adr[i]);
            chk8("reset value", rst_val[i], got);
        end
        chk1("oe reset", 1'b0, pin_oe);
        for (i = 0; i < 4; i++) begin
            k = $random(seed);
            wr_reg(ccm_pkg::CCM_ADDR_LOW, k[7:0]);
            wr_reg(ccm_pkg::CCM_ADDR_HIGH, k[15:8]);
            wr_reg(ccm_pkg::CCM_ADDR_CTRL, k[23:16] & 8'hF0);
            rd_reg(ccm_pkg::CCM_ADDR_LOW);
            chk8("low rw", k[7:0], got);
            rd_reg(ccm_pkg::CCM_ADDR_HIGH);
            chk8("high rw", k[15:8], got);
            rd_reg(ccm_pkg::CCM_ADDR_CTRL);
            chk8("ctrl rw", k[23:16] & 8'h30, got);
        end
        val = k[15:0];
        // The first capture mode runs masked and leaves its flag set, so
        // later captures overwrite values that were never collected.
        for (i = 4; i < 8; i++) begin
            en = (i != 4);
            wr_reg(ccm_pkg::CCM_ADDR_IEN, 8'h00);
            set_mode(0);
            set_mode(i);
            wr_reg(ccm_pkg::CCM_ADDR_IEN, 8'(en * 4));
            for (k = 0; k < 18; k++) begin
                pin_step(1'b1, 1'b0);
                pin_step(1'b0, 1'b0);
            end
        end
        set_mode(6);
        for (k = 0; k < 4; k++) begin
            pin_step(1'b1, 1'b0);
            pin_step(1'b0, 1'b0);
        end
        set_mode(5);
        wr_reg(ccm_pkg::CCM_ADDR_DIR, 8'h00);
        chk1("pin oe", 1'b1, pin_oe);
        pin_step(1'b1, 1'b1);
        pin_step(1'b0, 1'b1);
        wr_reg(ccm_pkg::CCM_ADDR_DIR, 8'h04);
        chk1("pin oe off", 1'b0, pin_oe);
        set_mode(0);
        wr_reg(ccm_pkg::CCM_ADDR_LOW, 8'h34);
        wr_reg(ccm_pkg::CCM_ADDR_HIGH, 8'h12);
        wr_reg(ccm_pkg::CCM_ADDR_DIR, 8'h00);
        tval <= 16'h1228;
        for (i = 0; i < 5; i++) begin
            set_mode(cmp_mode[i]);
            tld <= 1'b0;
            trun <= 1'b1;
            k = 0;
            while (irq !== 1'b1 && k < 40) begin
                @(posedge clk);
                k = k + 1;
            end
            chk1("match irq", 1'b1, irq);
            chk1("match pin", cmp_pin[i], pin_out);
            trun <= 1'b0;
            tld <= 1'b1;
            wr_reg(ccm_pkg::CCM_ADDR_FLAG, 8'h04);
        end
        set_mode(0);
        // A compare mode shows the output latch that the off code cleared.
        set_mode(10);
        chk1("pin off", 1'b0, pin_out);
        adc_en <= 1'b1;
        set_mode(11);
        tld <= 1'b0;
        trun <= 1'b1;
        k = 0;
        while (tmr_rst !== 1'b1 && k < 40) begin
            @(posedge clk);
            k = k + 1;
        end
        chk1("adc start", 1'b1, adc_go);
        trun <= 1'b0;
        tld <= 1'b1;
        #1;
        chk1("timer cleared", 1'b1, tmr === 16'h0000);
        @(posedge clk);
        set_mode(0);
        wr_reg(ccm_pkg::CCM_ADDR_LOW, 8'h40);
        set_mode(8'h2C);
        per_rl <= 1'b1;
        @(posedge clk);
        per_rl <= 1'b0;
        @(posedge clk);
        chk1("pwm set", 1'b1, pin_out);
        wr_reg(ccm_pkg::CCM_ADDR_HIGH, 8'h11);
        rd_reg(ccm_pkg::CCM_ADDR_HIGH);
        chk8("duty latched", 8'h40, got);
        per_cnt <= 8'h40;
        per_ph <= 2'h2;
        repeat (3) @(posedge clk);
        chk1("pwm clear", 1'b0, pin_out);
        complete_run();
    end
endmodule
